/* dv/acpi_sleep_state_rail_sequencer_tb.sv */
// bench of the sleep-state rail sequencer with a chipset model
// assumes the short counts 4, 20, 30 and 40 cycles set below
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected %0t got %h want %h", $time, a, b); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 400) begin \
   @(posedge clk); n++; end if (!(c)) begin fail_count++; stop_test(); end end
module acpi_sleep_state_rail_sequencer_tb;
   logic clk = 0, arst_n = 0, m33 = 0, m5 = 0, ram_n = 1, off_n = 1;
   logic keep = 0, auxs = 0, top = 0, ext = 0, cyc = 0, stb = 0, we = 0;
   logic [3:0] adr = 4'h0, rails;
   logic [31:0] wdat = 32'h0000_0000, rdat, q, seed = 32'h0a04;
   logic ack, d33, d5, cpu, aux, oe, uvf, uva, rpin, opin;
   logic bias = 0, mso;
   logic [1:0] noise = 2'h0;
   asrs_pkg::asrs_ss_t ss;
   int fail_count = 0, tests_run = 0, n, rcnt = 0;
   assign rails = {d33, d5, cpu, aux};
   asrs_chipset_model chip_u (.clk(clk), .ram_n(ram_n), .off_n(off_n),
      .noise(noise), .ram_pin_n(rpin), .off_pin_n(opin));
   asrs_sequencer #(.DEG_CYC(4), .ENTRY_CYC(20), .GAP_CYC(30),
      .MAIN_CYC(40)) dut_u (.SYS_CLK(clk), .ARST_N(arst_n),
      .STANDBY_BIAS_OK(bias), .MAIN33_OK(m33), .MAIN5_OK(m5),
      .RAM_SLEEP_REQ_N(rpin), .SOFT_OFF_REQ_N(opin),
      .DUAL5_KEEP_ON_STRAP(keep), .AUX_ALWAYS_ON_STRAP(auxs),
      .SS_RAMP_TOP(top), .SS_EXT_LOW(ext), .DUAL33_RAIL(d33),
      .DUAL5_RAIL(d5), .CPU_ID_RAIL(cpu), .AUX_ADJUSTABLE_RAIL(aux),
      .MAIN_SWITCH_RELEASE_O(mso), .MAIN_SWITCH_RELEASE_OE(oe),
      .SS_LEVEL(ss), .UNDERVOLT_MONITOR_FIRST(uvf),
      .UNDERVOLT_MONITOR_ALL(uva), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack));
   always #10 clk = ~clk;
   // ramp stand-in: reaches its top a few cycles into each ramp
   always @(posedge clk) begin
      rcnt <= (ss == asrs_pkg::SS_RAMP) ? rcnt + 1 : 0;
      top <= (rcnt >= 6);
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // expected rails per state: 0 active, 3 ram sleep, 5 soft-off
   function automatic logic [3:0] exp_rails(input int k);
      return {1'b1, k != 5 || keep, k == 0, k == 0 || auxs};
   endfunction
   // one classic cycle, entered just after an edge
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int t;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      t = 0;
      do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 20);
      if (ack !== 1'b1) begin fail_count++; stop_test(); end
      q = rdat;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
   endtask
   task stop_test;
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ********************
   // main sequence
   // ********************
   initial begin
      seed = xs(seed);
      keep <= seed[0];
      auxs <= seed[1];
      repeat (6) @(posedge clk);
      arst_n <= 1;
      bias <= 1;
      `WAITC(uvf === 1'b1) `CHK(ss, asrs_pkg::SS_HOLD_LOW)
      `CHK({d33, aux, cpu, oe}, {1'b1, auxs, 2'b01})
      `WAITC(ss === asrs_pkg::SS_RAMP) `CHK(n >= 30, 1'b1)
      `WAITC(uva === 1'b1) `CHK(ss, asrs_pkg::SS_HOLD_LOW)
      `CHK(cpu, 1'b0)
      m33 <= 1;
      repeat (60) @(posedge clk);
      `CHK(oe, 1'b1)
      m5 <= 1;
      `WAITC(oe === 1'b0) `CHK(n >= 40, 1'b1)
      `CHK({cpu, ss, mso}, {1'b1, asrs_pkg::SS_RAMP, 1'b0})
      `WAITC(ss === asrs_pkg::SS_HOLD_HIGH) `CHK(rails, exp_rails(0))
      seed = xs(seed);
      noise <= seed[1:0] | 2'h1;
      @(posedge clk);
      noise <= 2'h0;
      repeat (30) @(posedge clk);
      `CHK(cpu, 1'b1)
      ram_n <= 0;
      `WAITC(cpu === 1'b0) `CHK(n >= 20, 1'b1)
      repeat (5) @(posedge clk);
      `CHK(rails, exp_rails(3))
      off_n <= 0;
      repeat (30) @(posedge clk);
      `CHK(rails, exp_rails(5))
      off_n <= 1;
      repeat (30) @(posedge clk);
      `CHK(rails, exp_rails(5))
      wb(0, 4'h4, 32'h0000_0000);
      `CHK(q[7], 1'b1)
      off_n <= 0;
      repeat (30) @(posedge clk);
      wb(1, 4'h0, 32'h0000_0002);
      wb(0, 4'h4, 32'h0000_0000);
      `CHK(q[7], 1'b0)
      wb(0, 4'h8, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      ram_n <= 1;
      off_n <= 1;
      `WAITC(ss === asrs_pkg::SS_HOLD_HIGH) `CHK(rails, exp_rails(0))
      m5 <= 0;
      `WAITC(cpu === 1'b0) `CHK(rails, exp_rails(5))
      m5 <= 1;
      `WAITC(ss === asrs_pkg::SS_HOLD_HIGH) `CHK(rails, exp_rails(0))
      ext <= 1;
      repeat (10) @(posedge clk);
      `CHK(rails, 4'h0)
      ext <= 0;
      `WAITC(d33 === 1'b1) `CHK(ss, asrs_pkg::SS_RAMP)
      // software shutdown acts like the node held low
      wb(1, 4'h0, 32'h0000_0001);
      wb(0, 4'h0, 32'h0000_0000);
      `CHK({q, rails}, {32'h0000_0001, 4'h0})
      wb(1, 4'h0, 32'h0000_0000);
      // bias lost, then back with both requests low: sleep start-up
      bias <= 0;
      ram_n <= 0;
      off_n <= 0;
      repeat (10) @(posedge clk);
      `CHK(rails, 4'h0)
      bias <= 1;
      `WAITC(uva === 1'b1) `CHK(rails, exp_rails(5))
      stop_test();
   end
endmodule // acpi_sleep_state_rail_sequencer_tb

/* dv/asrs_chipset_model.sv */
// chipset side model: drives the two active-low sleep requests
// assumes the bench commands levels and the length of noise bursts
`timescale 1ns/1ps
module asrs_chipset_model (
   input  wire logic       clk,
   input  wire logic       ram_n,
   input  wire logic       off_n,
   input  wire logic [1:0] noise,
   output logic            ram_pin_n,
   output logic            off_pin_n
);
   logic [1:0] left_reg = 2'h0;
   // a burst shorter than the filter, so no sleep may follow
   always_ff @(posedge clk) begin
      left_reg <= (noise != 2'h0) ? noise
                  : left_reg - {1'b0, left_reg != 2'h0};
   end
   assign ram_pin_n = ram_n ^ (left_reg != 2'h0);
   assign off_pin_n = off_n; // pair stays a legal code
endmodule // asrs_chipset_model

/* shared/asrs_params.svh */
// constants of the sleep-state rail sequencer: timing, offsets, fields
// assumes a single system clock whose rate is given in whole megahertz
`ifndef ASRS_PARAMS_SVH
`define ASRS_PARAMS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define ASRS_CLK_MHZ       50
`define ASRS_DEGLITCH_NS   2000
`define ASRS_ENTRY_US      200
`define ASRS_GAP_US        3000
`define ASRS_MAIN_US       50000
`define ASRS_CNT_W         22
// synchroniser reset: requests and straps idle high through pull-ups
`define ASRS_SYNC_RST      9'h03C

// ****************************************************************
// register map (byte offsets) and control fields
// ****************************************************************
`define ASRS_ADR_W         4
`define ASRS_ADR_CTRL      4'h0
`define ASRS_ADR_STATUS    4'h4
`define ASRS_CTRL_SHDN     0
`define ASRS_CTRL_CLRREF   1
`define ASRS_CTRL_RST      1'h0
`define ASRS_STAT_PAD      15

`endif

/* shared/asrs_pkg.sv */
// types shared by the sleep-state rail sequencer and its bench
// assumes the constants header is included by the design files
package asrs_pkg;

   // sequencer states
   typedef enum logic [3:0] {
      ST_POR,
      ST_SS1,
      ST_GAP,
      ST_SS2,
      ST_SLEEP,
      ST_MAIN_WAIT,
      ST_ACT_RAMP,
      ST_ACTIVE,
      ST_ENTRY
   } asrs_state_t;

   // which sleep state is held (or active wake-up)
   typedef enum logic [1:0] {
      KIND_ACT,
      KIND_S3,
      KIND_S5
   } asrs_kind_t;

   // soft-start node command
   typedef enum logic [1:0] {
      SS_OFF,
      SS_RAMP,
      SS_HOLD_LOW,
      SS_HOLD_HIGH
   } asrs_ss_t;

   // rail enables travel together
   typedef struct packed {
      logic dual33;
      logic dual5;
      logic cpu_id;
      logic aux;
      logic main_rel;
   } asrs_rails_t;

   // status word as software sees it
   typedef struct packed {
      logic        uv_all;
      logic        uv_first;
      asrs_ss_t    ss;
      asrs_rails_t rails;
      logic        refused;
      logic        forced;
      asrs_kind_t  kind;
      asrs_state_t state;
   } asrs_status_t;

endpackage

/* src/asrs_deglitch.sv */
// deglitch filter for one synchronised active-low request level
// assumes the input is already in the SYS_CLK domain
`timescale 1ns/1ps

module asrs_deglitch #(
   parameter int CYCLES = 100
) (
   input  wire logic SYS_CLK,
   input  wire logic ARST_N,
   input  wire logic LEVEL_IN,
   output logic      LEVEL_OUT
);

   logic [15:0] cnt_reg;
   logic        out_reg;
   wire  logic  differs = LEVEL_IN != out_reg;
   wire  logic  done    = cnt_reg == 16'(CYCLES - 1);

   // output follows only after the input held its new level long enough;
   // pullups make the idle level high, so reset to high
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_reg <= 16'h0000;
         out_reg <= 1'b1;
      end else if (!differs) begin
         cnt_reg <= 16'h0000;
      end else if (done) begin
         cnt_reg <= 16'h0000;
         out_reg <= LEVEL_IN;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   assign LEVEL_OUT = out_reg;

endmodule // asrs_deglitch

/* src/asrs_sequencer.sv */
// sleep-state rail sequencer: request decode, soft-start phases, rails
// assumes analog ramp and supply monitors arrive as threshold flags
`timescale 1ns/1ps
`include "asrs_params.svh"

module asrs_sequencer #(
   parameter int CLK_MHZ   = `ASRS_CLK_MHZ,
   parameter int DEG_CYC   = (`ASRS_DEGLITCH_NS * `ASRS_CLK_MHZ + 999) / 1000,
   parameter int ENTRY_CYC = `ASRS_ENTRY_US * `ASRS_CLK_MHZ,
   parameter int GAP_CYC   = `ASRS_GAP_US * `ASRS_CLK_MHZ,
   parameter int MAIN_CYC  = `ASRS_MAIN_US * `ASRS_CLK_MHZ
) (
   input  wire logic                     SYS_CLK,
   input  wire logic                     ARST_N,
   input  wire logic                     STANDBY_BIAS_OK,
   input  wire logic                     MAIN33_OK,
   input  wire logic                     MAIN5_OK,
   input  wire logic                     RAM_SLEEP_REQ_N,
   input  wire logic                     SOFT_OFF_REQ_N,
   input  wire logic                     DUAL5_KEEP_ON_STRAP,
   input  wire logic                     AUX_ALWAYS_ON_STRAP,
   input  wire logic                     SS_RAMP_TOP,
   input  wire logic                     SS_EXT_LOW,
   output logic                          DUAL33_RAIL,
   output logic                          DUAL5_RAIL,
   output logic                          CPU_ID_RAIL,
   output logic                          AUX_ADJUSTABLE_RAIL,
   output logic                          MAIN_SWITCH_RELEASE_O,
   output logic                          MAIN_SWITCH_RELEASE_OE,
   output asrs_pkg::asrs_ss_t            SS_LEVEL,
   output logic                          UNDERVOLT_MONITOR_FIRST,
   output logic                          UNDERVOLT_MONITOR_ALL,
   input  wire logic                     WB_CYC_I,
   input  wire logic                     WB_STB_I,
   input  wire logic                     WB_WE_I,
   input  wire logic [`ASRS_ADR_W-1:0]   WB_ADR_I,
   input  wire logic [3:0]               WB_SEL_I,
   input  wire logic [31:0]              WB_DAT_I,
   output logic [31:0]                   WB_DAT_O,
   output logic                          WB_ACK_O
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] meta_reg;
   logic [NSYNC-1:0] sync_reg;
   wire  logic [NSYNC-1:0] pins = {STANDBY_BIAS_OK, MAIN33_OK, MAIN5_OK,
      RAM_SLEEP_REQ_N, SOFT_OFF_REQ_N, DUAL5_KEEP_ON_STRAP,
      AUX_ALWAYS_ON_STRAP, SS_RAMP_TOP, SS_EXT_LOW};

   // two flops per pin; pull-up pins idle high, so requests reset high
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         meta_reg <= `ASRS_SYNC_RST;
         sync_reg <= `ASRS_SYNC_RST;
      end else begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
      end
   end

   wire logic bias_ok  = sync_reg[8];
   wire logic mains_ok = sync_reg[7] & sync_reg[6];
   wire logic ram_sync = sync_reg[5];
   wire logic off_sync = sync_reg[4];
   wire logic keep5_s  = sync_reg[3];
   wire logic auxon_s  = sync_reg[2];
   wire logic ramp_top = sync_reg[1];
   wire logic ext_low  = sync_reg[0];

   // ****************************************************************
   // request deglitch
   // ****************************************************************
   logic ram_n;
   logic off_n;

   // short pulses on either request reach the state logic only through the unfiltered ST_POR kind decode of ram_sync and off_sync
   asrs_deglitch #(.CYCLES(DEG_CYC)) u_ram_filt (
      .SYS_CLK   (SYS_CLK),
      .ARST_N    (ARST_N),
      .LEVEL_IN  (ram_sync),
      .LEVEL_OUT (ram_n)
   );
   asrs_deglitch #(.CYCLES(DEG_CYC)) u_off_filt (
      .SYS_CLK   (SYS_CLK),
      .ARST_N    (ARST_N),
      .LEVEL_IN  (off_sync),
      .LEVEL_OUT (off_n)
   );

   // ****************************************************************
   // control register
   // ****************************************************************
   logic ctrl_shdn_reg;
   logic ack_reg;
   logic [31:0] rdat_reg;
   wire  logic bus_req  = WB_CYC_I & WB_STB_I & ~ack_reg;
   wire  logic wr_ctrl  = bus_req & WB_WE_I & WB_SEL_I[0] &
                          (WB_ADR_I == `ASRS_ADR_CTRL);
   wire  logic clr_ref  = wr_ctrl & WB_DAT_I[`ASRS_CTRL_CLRREF];
   // external low on the node or software shutdown both stop everything
   wire  logic shutdown = ext_low | ctrl_shdn_reg | ~bias_ok;

   // ****************************************************************
   // sequencer state
   // ****************************************************************
   asrs_pkg::asrs_state_t state_reg;
   asrs_pkg::asrs_state_t state_next;
   asrs_pkg::asrs_kind_t  kind_reg;
   asrs_pkg::asrs_kind_t  kind_next;
   logic [`ASRS_CNT_W-1:0] cnt_reg;
   logic forced_reg;
   logic refused_reg;
   logic uv1_reg;
   logic uvall_reg;
   logic keep5_reg;
   logic auxon_reg;

   wire logic both_high = ram_n & off_n;
   wire logic cnt_zero_next = state_next != state_reg;
   wire logic main_hold = ~mains_ok & (state_reg == asrs_pkg::ST_MAIN_WAIT);
   wire logic entry_done = cnt_reg == `ASRS_CNT_W'(ENTRY_CYC - 1);
   wire logic gap_done   = cnt_reg == `ASRS_CNT_W'(GAP_CYC - 1);
   wire logic main_done  = cnt_reg == `ASRS_CNT_W'(MAIN_CYC - 1);
   wire logic in_act = (state_reg == asrs_pkg::ST_ACT_RAMP) |
                       (state_reg == asrs_pkg::ST_ACTIVE) |
                       (state_reg == asrs_pkg::ST_ENTRY);
   // soft-off held while the pair asks for ram sleep: refused
   wire logic s5_to_s3 = (state_reg == asrs_pkg::ST_SLEEP) &
                         (kind_reg == asrs_pkg::KIND_S5) &
                         ~forced_reg & off_n & ~ram_n;

   // next state; shutdown dominates every phase, supply loss the active ones
   always_comb begin
      state_next = state_reg;
      kind_next  = kind_reg;
      if (shutdown) begin
         state_next = asrs_pkg::ST_POR;
      end else if (in_act & ~mains_ok) begin
         state_next = asrs_pkg::ST_SLEEP;
         kind_next  = asrs_pkg::KIND_S5;
      end else begin
         case (state_reg)
            asrs_pkg::ST_POR: begin
               state_next = asrs_pkg::ST_SS1;
               if (ram_sync & off_sync)
                  kind_next = asrs_pkg::KIND_ACT;
               else if (off_sync)
                  kind_next = asrs_pkg::KIND_S3;
               else
                  kind_next = asrs_pkg::KIND_S5;
            end
            asrs_pkg::ST_SS1:
               if (ramp_top)
                  state_next = asrs_pkg::ST_GAP;
            asrs_pkg::ST_GAP:
               if (gap_done)
                  state_next = asrs_pkg::ST_SS2;
            asrs_pkg::ST_SS2:
               if (ramp_top)
                  state_next = (kind_reg == asrs_pkg::KIND_ACT) ?
                     asrs_pkg::ST_MAIN_WAIT : asrs_pkg::ST_SLEEP;
            asrs_pkg::ST_SLEEP: begin
               if (forced_reg ? mains_ok : (both_high & mains_ok))
                  state_next = asrs_pkg::ST_MAIN_WAIT;
               else if (~forced_reg & ~off_n & ~ram_n)
                  kind_next = asrs_pkg::KIND_S5;
            end
            asrs_pkg::ST_MAIN_WAIT: begin
               if (~forced_reg & ~both_high & (kind_reg != asrs_pkg::KIND_ACT))
                  state_next = asrs_pkg::ST_SLEEP;
               else if (main_done & mains_ok)
                  state_next = asrs_pkg::ST_ACT_RAMP;
            end
            asrs_pkg::ST_ACT_RAMP:
               if (ramp_top)
                  state_next = asrs_pkg::ST_ACTIVE;
            asrs_pkg::ST_ACTIVE:
               if (~ram_n)
                  state_next = asrs_pkg::ST_ENTRY;
            asrs_pkg::ST_ENTRY: begin
               if (ram_n) begin
                  state_next = asrs_pkg::ST_ACTIVE;
               end else if (entry_done) begin
                  state_next = asrs_pkg::ST_SLEEP;
                  kind_next  = off_n ? asrs_pkg::KIND_S3 :
                                       asrs_pkg::KIND_S5;
               end
            end
            default: state_next = asrs_pkg::ST_POR;
         endcase
      end
   end

   // counter restarts on every change and while mains are invalid in ST_MAIN_WAIT
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N)
         cnt_reg <= '0;
      else if (cnt_zero_next | main_hold)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + `ASRS_CNT_W'(1);
   end

   // state, kind and straps caught as start-up leaves reset
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= asrs_pkg::ST_POR;
         kind_reg  <= asrs_pkg::KIND_S5;
         keep5_reg <= 1'b1;
         auxon_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         kind_reg  <= kind_next;
         if (state_reg == asrs_pkg::ST_POR) begin
            keep5_reg <= keep5_s;
            auxon_reg <= auxon_s;
         end
      end
   end

   // forced soft-off marker, where a clear beats a set, and sticky refusal flag, where a set beats a clear
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         forced_reg  <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         if (shutdown | (state_next == asrs_pkg::ST_ACTIVE))
            forced_reg <= 1'b0;
         else if (in_act & ~mains_ok)
            forced_reg <= 1'b1;
         if (s5_to_s3)
            refused_reg <= 1'b1;
         else if (clr_ref)
            refused_reg <= 1'b0;
      end
   end

   // monitor arming follows the ramp tops; cleared by any restart
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         uv1_reg   <= 1'b0;
         uvall_reg <= 1'b0;
      end else if (state_reg == asrs_pkg::ST_POR) begin
         uv1_reg   <= 1'b0;
         uvall_reg <= 1'b0;
      end else begin
         if ((state_reg == asrs_pkg::ST_SS1) & ramp_top)
            uv1_reg <= 1'b1;
         if (ramp_top & ((state_reg == asrs_pkg::ST_SS2) |
                         (state_reg == asrs_pkg::ST_ACT_RAMP)))
            uvall_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // rail decode
   // ****************************************************************
   asrs_pkg::asrs_rails_t rails;
   asrs_pkg::asrs_ss_t    ss_cmd;
   wire logic up     = state_reg != asrs_pkg::ST_POR;
   wire logic second = up & (state_reg != asrs_pkg::ST_SS1) &
                       (state_reg != asrs_pkg::ST_GAP);
   // dual 5V in sleep: on in S3, strap-dependent in soft-off
   wire logic sleep5 = (kind_reg == asrs_pkg::KIND_S3) |
                       ((kind_reg == asrs_pkg::KIND_S5) & keep5_reg);

   assign rails.dual33   = up;
   assign rails.dual5    = in_act | (second & sleep5);
   assign rails.cpu_id   = in_act;
   assign rails.aux      = in_act | (up & auxon_reg);
   assign rails.main_rel = in_act;

   // soft-start node command per phase
   assign ss_cmd = ~up ? asrs_pkg::SS_OFF :
      ((state_reg == asrs_pkg::ST_SS1) | (state_reg == asrs_pkg::ST_SS2) |
       (state_reg == asrs_pkg::ST_ACT_RAMP)) ? asrs_pkg::SS_RAMP :
      ((state_reg == asrs_pkg::ST_ACTIVE) | (state_reg == asrs_pkg::ST_ENTRY))
         ? asrs_pkg::SS_HOLD_HIGH : asrs_pkg::SS_HOLD_LOW;

   // outputs straight from decoded registered state
   assign DUAL33_RAIL             = rails.dual33;
   assign DUAL5_RAIL              = rails.dual5;
   assign CPU_ID_RAIL             = rails.cpu_id;
   assign AUX_ADJUSTABLE_RAIL     = rails.aux;
   assign MAIN_SWITCH_RELEASE_O   = 1'b0;
   assign MAIN_SWITCH_RELEASE_OE  = ~rails.main_rel;
   assign SS_LEVEL                = ss_cmd;
   assign UNDERVOLT_MONITOR_FIRST = uv1_reg;
   assign UNDERVOLT_MONITOR_ALL   = uvall_reg;

   // ****************************************************************
   // wishbone slave
   // ****************************************************************
   asrs_pkg::asrs_status_t status;
   assign status = '{uv_all: uvall_reg, uv_first: uv1_reg, ss: ss_cmd,
                     rails: rails, refused: refused_reg, forced: forced_reg,
                     kind: kind_reg, state: state_reg};
   wire logic [31:0] rd_mux =
      (WB_ADR_I == `ASRS_ADR_CTRL) ? {30'h0000_0000, 1'b0, ctrl_shdn_reg} :
      (WB_ADR_I == `ASRS_ADR_STATUS) ?
         {`ASRS_STAT_PAD'h000, status} : 32'h0000_0000;

   // one wait state; unmapped offsets ack with zero data, writes dropped
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_reg       <= 1'b0;
         rdat_reg      <= 32'h0000_0000;
         ctrl_shdn_reg <= `ASRS_CTRL_RST;
      end else begin
         ack_reg  <= bus_req;
         rdat_reg <= bus_req ? rd_mux : 32'h0000_0000;
         if (wr_ctrl)
            ctrl_shdn_reg <= WB_DAT_I[`ASRS_CTRL_SHDN];
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdat_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   vid_active_only_a: assert property (
      CPU_ID_RAIL |-> $past(mains_ok) && SS_LEVEL != asrs_pkg::SS_HOLD_LOW)
      else $error("cpu id rail on outside active");
   active_needs_mains_a: assert property (
      $rose(state_reg == asrs_pkg::ST_ACT_RAMP) |-> $past(mains_ok))
      else $error("active ramp entered without valid mains");
   forced_soft_off_a: assert property (
      (in_act & ~mains_ok & ~shutdown) |=>
         state_reg == asrs_pkg::ST_SLEEP && kind_reg == asrs_pkg::KIND_S5)
      else $error("supply loss did not force soft-off");
   no_s5_to_s3_a: assert property (
      (state_reg == asrs_pkg::ST_SLEEP && kind_reg == asrs_pkg::KIND_S5)
         |=> kind_reg != asrs_pkg::KIND_S3)
      else $error("soft-off changed to ram sleep");
   dual5_strap_a: assert property (
      (state_reg == asrs_pkg::ST_SLEEP && kind_reg == asrs_pkg::KIND_S5)
         |-> DUAL5_RAIL == keep5_reg && DUAL33_RAIL)
      else $error("soft-off dual rails wrong");
   aux_gigabit_a: assert property (
      (!auxon_reg && !in_act) |-> !AUX_ADJUSTABLE_RAIL)
      else $error("aux rail on in gigabit sleep");
   entry_delay_a: assert property (
      (state_reg == asrs_pkg::ST_ENTRY ##1 state_reg == asrs_pkg::ST_SLEEP
         && mains_ok) |-> $past(entry_done, 1))
      else $error("sleep entered before entry delay");
   switch_release_a: assert property (
      $fell(MAIN_SWITCH_RELEASE_OE) |->
         SS_LEVEL == asrs_pkg::SS_RAMP && $past(main_done))
      else $error("main switch released off ramp start");
   hold_high_a: assert property (
      state_reg == asrs_pkg::ST_ACTIVE |-> SS_LEVEL == asrs_pkg::SS_HOLD_HIGH)
      else $error("active hold level wrong");
   shutdown_off_a: assert property (
      ext_low |=> !DUAL33_RAIL && !DUAL5_RAIL && !AUX_ADJUSTABLE_RAIL)
      else $error("rails on while node held low");
   wb_ack_pulse_a: assert property (
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held over two cycles");

endmodule // asrs_sequencer
